// file: strap_cfg_pkg.sv
`default_nettype none
package strap_cfg_pkg;

    // Register image geometry
    localparam int REG_W     = 8;
    localparam int CFG_COUNT = 8;
    localparam int ADDR_W    = 6;
    localparam int IDX_W     = 4;
    localparam int SYNC_STAGES = 2;

    // Register indices (byte offset is four times the index)
    localparam logic [IDX_W-1:0] IDX_HS_MODES    = 4'h0;
    localparam logic [IDX_W-1:0] IDX_AUX_MODES   = 4'h1;
    localparam logic [IDX_W-1:0] IDX_RX_SETTINGS = 4'h2;
    localparam logic [IDX_W-1:0] IDX_TERM_PULSE1 = 4'h3;
    localparam logic [IDX_W-1:0] IDX_TERM_PULSE2 = 4'h4;
    localparam logic [IDX_W-1:0] IDX_RX_EQ1      = 4'h5;
    localparam logic [IDX_W-1:0] IDX_RX_EQ2      = 4'h6;
    localparam logic [IDX_W-1:0] IDX_TX_SETTINGS = 4'h7;
    localparam logic [IDX_W-1:0] IDX_STATUS      = 4'h8;

    // Field positions inside the register images
    localparam int ENABLE_BIT  = 6;
    localparam int MODE_LSB    = 4;
    localparam int SRC_LSB     = 0;
    localparam int RX_TERM_BIT = 0;
    localparam int PE_LSB      = 2;
    localparam int OTO_BIT     = 1;
    localparam int OCL_BIT     = 0;
    localparam int SERIAL_BIT  = 0;

    // Field positions of the synchronised strap bundle
    localparam int STRAP_W   = 8;
    localparam int SP_EN     = 7;
    localparam int SP_SRC    = 5;
    localparam int SP_EQ     = 4;
    localparam int SP_PE     = 2;
    localparam int SP_OTO    = 1;
    localparam int SP_OCL    = 0;

    // Field encodings
    localparam logic [1:0] BUNDLE_QUAD = 2'h0;
    localparam logic       SWITCH_ON   = 1'h1;
    localparam logic       RX_TERM_ON  = 1'h1;
    localparam logic [7:0] PULSE_OFF   = 8'h00;
    localparam logic       EQ_6DB      = 1'h0;
    localparam logic       EQ_12DB     = 1'h1;
    localparam logic       OTO_ON      = 1'h1;
    localparam logic       OCL_20MA    = 1'h1;

    typedef enum logic [1:0] {
        SRC_A = 2'h0, SRC_B = 2'h1, SRC_C = 2'h2, SRC_D = 2'h3
    } source_type;

    typedef enum logic [1:0] {
        PE_0DB = 2'h0, PE_2DB = 2'h1, PE_4DB = 2'h2, PE_6DB = 2'h3
    } preemph_type;

    // Reset image: standby, aux on, input termination on, all else zero
    localparam logic [CFG_COUNT-1:0][REG_W-1:0] RST_IMAGE = {
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h40, 8'h00
    };

endpackage : strap_cfg_pkg
`default_nettype wire

// file: strap_sync.sv
`default_nettype none
module strap_sync
    import strap_cfg_pkg::*;
#(
    parameter int W = STRAP_W
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] stage1_q;

    // Two flops; only the second stage is ever looked at
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stage1_q <= '0;
            dout     <= '0;
        end else begin
            stage1_q <= din;
            dout     <= stage1_q;
        end
    end

endmodule : strap_sync
`default_nettype wire

// file: strap_field_mapper.sv
`default_nettype none
module strap_field_mapper
    import strap_cfg_pkg::*;
(
    input  wire logic [STRAP_W-1:0]                straps,
    output logic      [CFG_COUNT-1:0][REG_W-1:0]   image
);

    // Build every register image from the strap bundle
    always_comb begin
        image = '0;
        image[IDX_HS_MODES][ENABLE_BIT]              = straps[SP_EN];
        image[IDX_HS_MODES][MODE_LSB +: 2]           = BUNDLE_QUAD;
        image[IDX_HS_MODES][SRC_LSB +: 2]            = straps[SP_SRC +: 2];
        image[IDX_AUX_MODES][ENABLE_BIT]             = SWITCH_ON;
        image[IDX_AUX_MODES][MODE_LSB +: 2]          = BUNDLE_QUAD;
        image[IDX_AUX_MODES][SRC_LSB +: 2]           = straps[SP_SRC +: 2];
        image[IDX_RX_SETTINGS][RX_TERM_BIT]          = RX_TERM_ON;
        image[IDX_TERM_PULSE1]                       = PULSE_OFF;
        image[IDX_TERM_PULSE2]                       = PULSE_OFF;
        image[IDX_RX_EQ1]                            = {REG_W{straps[SP_EQ]}};
        image[IDX_RX_EQ2]                            = {REG_W{straps[SP_EQ]}};
        image[IDX_TX_SETTINGS][PE_LSB +: 2]          = straps[SP_PE +: 2];
        image[IDX_TX_SETTINGS][OTO_BIT]              = straps[SP_OTO];
        image[IDX_TX_SETTINGS][OCL_BIT]              = straps[SP_OCL];
    end

endmodule : strap_field_mapper
`default_nettype wire

// file: parallel_pin_config_decoder.sv
// The address map and the Avalon-MM slave port were chosen for this implementation.
`default_nettype none
module parallel_pin_config_decoder
    import strap_cfg_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst,
    // Strap pins
    input  wire logic              channel_enable_strap,
    input  wire logic [1:0]        source_select_strap,
    input  wire logic              equalizer_level_strap,
    input  wire logic [1:0]        preemphasis_level_strap,
    input  wire logic              output_termination_strap,
    input  wire logic              output_current_strap,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [31:0]       writedata,
    input  wire logic [3:0]        byteenable,
    output logic      [31:0]       readdata,
    output logic                   waitrequest,
    // Switch controls
    output logic      [REG_W-1:0]  hsModes,
    output logic      [REG_W-1:0]  auxModes,
    output logic      [REG_W-1:0]  rxSettings,
    output logic      [REG_W-1:0]  termPulse1,
    output logic      [REG_W-1:0]  termPulse2,
    output logic      [REG_W-1:0]  rxEq1,
    output logic      [REG_W-1:0]  rxEq2,
    output logic      [REG_W-1:0]  txSettings,
    output logic                   serialMode
);

    ////////////////////////////////////////////////////////////////////////
    // Strap capture

    logic [STRAP_W-1:0]              strapRaw;
    logic [STRAP_W-1:0]              strapSync;
    logic [CFG_COUNT-1:0][REG_W-1:0] strapImage;

    // Pins bundled so one synchroniser instance covers them all
    assign strapRaw = {channel_enable_strap, source_select_strap,
                       equalizer_level_strap, preemphasis_level_strap,
                       output_termination_strap, output_current_strap};

    // Straps are static, so no per-bit skew handling is needed
    strap_sync #(
        .W (STRAP_W)
    ) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .din      (strapRaw),
        .dout     (strapSync)
    );

    strap_field_mapper u_mapper (
        .straps (strapSync),
        .image  (strapImage)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bus slave

    logic                            waitreq_q;
    logic [31:0]                     rdata_q;
    logic                            serial_q;
    logic [CFG_COUNT-1:0][REG_W-1:0] cfgImage_q;
    logic [IDX_W-1:0]                regIdx;
    logic                            aligned;
    logic                            accept;
    logic                            wrHit;
    logic [REG_W-1:0]                readMux;

    assign regIdx  = address[ADDR_W-1:2];
    assign aligned = (address[1:0] == 2'h0);
    assign accept  = (read || write) && !waitreq_q;
    assign wrHit   = accept && write && aligned && byteenable[0]
                     && (regIdx < IDX_W'(CFG_COUNT));

    // Read selection; misaligned or unmapped words read as zero
    always_comb begin
        readMux = '0;
        if (aligned) begin
            if (regIdx < IDX_W'(CFG_COUNT)) begin
                readMux = cfgImage_q[regIdx[2:0]];
            end else if (regIdx == IDX_STATUS) begin
                readMux[SERIAL_BIT] = serial_q;
            end
        end
    end

    // One wait cycle per access keeps readdata a clean flop output
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            waitreq_q <= 1'h1;
        end else if (accept) begin
            waitreq_q <= 1'h1;
        end else if (read || write) begin
            waitreq_q <= 1'h0;
        end
    end

    // Read data captured as waitrequest drops, held until the next read
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h0;
        end else if (read && waitreq_q) begin
            rdata_q <= {{(32-REG_W){1'b0}}, readMux};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration ownership

    // Any accepted access hands the controls to software for good
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            serial_q <= 1'h0;
        end else if (accept) begin
            serial_q <= 1'h1;
        end
    end

    // Mirror the straps until software owns the image; a write in the
    // handover cycle lands on top of the mirrored value
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cfgImage_q <= RST_IMAGE;
        end else begin
            if (!serial_q) begin
                cfgImage_q <= strapImage;
            end
            if (wrHit) begin
                cfgImage_q[regIdx[2:0]] <= writedata[REG_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flops

    assign readdata    = rdata_q;
    assign waitrequest = waitreq_q;
    assign serialMode  = serial_q;
    assign hsModes     = cfgImage_q[IDX_HS_MODES];
    assign auxModes    = cfgImage_q[IDX_AUX_MODES];
    assign rxSettings  = cfgImage_q[IDX_RX_SETTINGS];
    assign termPulse1  = cfgImage_q[IDX_TERM_PULSE1];
    assign termPulse2  = cfgImage_q[IDX_TERM_PULSE2];
    assign rxEq1       = cfgImage_q[IDX_RX_EQ1];
    assign rxEq2       = cfgImage_q[IDX_RX_EQ2];
    assign txSettings  = cfgImage_q[IDX_TX_SETTINGS];

    ////////////////////////////////////////////////////////////////////////
    // Reference decode for the checks

    source_type  refSource;
    preemph_type refPreemph;
    logic        refEqHigh;
    logic        refOutTerm;
    logic        refCurrent20;

    // Spelled out code by code with the named encodings, so a slip in the
    // mapper's bit slicing cannot hide behind an identical slice here
    always_comb begin
        refSource  = SRC_A;
        refPreemph = PE_0DB;
        unique case (strapSync[SP_SRC +: 2])
            2'h0: refSource = SRC_A;
            2'h1: refSource = SRC_B;
            2'h2: refSource = SRC_C;
            2'h3: refSource = SRC_D;
        endcase
        unique case (strapSync[SP_PE +: 2])
            2'h0: refPreemph = PE_0DB;
            2'h1: refPreemph = PE_2DB;
            2'h2: refPreemph = PE_4DB;
            2'h3: refPreemph = PE_6DB;
        endcase
    end

    // Single-bit straps against their named levels
    assign refEqHigh    = (strapSync[SP_EQ] == EQ_12DB);
    assign refOutTerm   = (strapSync[SP_OTO] == OTO_ON);
    assign refCurrent20 = (strapSync[SP_OCL] == OCL_20MA);

    ////////////////////////////////////////////////////////////////////////
    // Checks

    logic [1:0] settleCnt_q;

    // Counts edges since reset so sync checks skip the reset flush
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            settleCnt_q <= 2'h0;
        end else if (settleCnt_q != 2'h3) begin
            settleCnt_q <= settleCnt_q + 2'h1;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // A cycle in which the straps still own the image
    sequence mirrorCycle;
        !serial_q && !accept;
    endsequence

    // A request that has just been raised and is still waiting
    sequence freshRequest;
        (read || write) && waitreq_q;
    endsequence

    chk_quad_hs_mode: assert property (
        mirrorCycle |=> hsModes[MODE_LSB +: 2] == BUNDLE_QUAD
    ) else $error("high-speed bundling not quad in strap mode");

    chk_hs_enable: assert property (
        mirrorCycle |=> hsModes[ENABLE_BIT] == $past(strapSync[SP_EN])
    ) else $error("high-speed enable does not follow strap");

    chk_hs_source: assert property (
        mirrorCycle |=> hsModes[SRC_LSB +: 2] == $past(strapSync[SP_SRC +: 2])
    ) else $error("high-speed source does not follow strap");

    chk_aux_source: assert property (
        mirrorCycle |=> auxModes[SRC_LSB +: 2] == hsModes[SRC_LSB +: 2]
    ) else $error("aux source differs from high-speed source");

    chk_aux_always_on: assert property (
        mirrorCycle |=> auxModes[ENABLE_BIT] == SWITCH_ON
                        && auxModes[MODE_LSB +: 2] == BUNDLE_QUAD
    ) else $error("aux switch not enabled quad in strap mode");

    chk_rx_term_on: assert property (
        mirrorCycle |=> rxSettings[RX_TERM_BIT] == RX_TERM_ON
    ) else $error("input termination off in strap mode");

    chk_pulse_off: assert property (
        mirrorCycle |=> termPulse1 == PULSE_OFF && termPulse2 == PULSE_OFF
    ) else $error("termination pulse enabled in strap mode");

    chk_eq_common: assert property (
        mirrorCycle |=> rxEq1 == rxEq2 && (rxEq1 == '0 || rxEq1 == '1)
    ) else $error("equalizer level not common to all inputs");

    chk_eq_level: assert property (
        mirrorCycle |=> rxEq1[0] == ($past(strapSync[SP_EQ]) ? EQ_12DB : EQ_6DB)
    ) else $error("equalizer level does not follow strap");

    chk_tx_preemph: assert property (
        mirrorCycle |=> txSettings[PE_LSB +: 2] == $past(strapSync[SP_PE +: 2])
    ) else $error("pre-emphasis does not follow strap");

    chk_tx_term: assert property (
        mirrorCycle |=> txSettings[OTO_BIT] == $past(strapSync[SP_OTO])
    ) else $error("output termination does not follow strap");

    chk_tx_current: assert property (
        mirrorCycle |=> txSettings[OCL_BIT] == $past(strapSync[SP_OCL])
    ) else $error("output current does not follow strap");

    chk_serial_latch: assert property (
        accept |=> serial_q [*3]
    ) else $error("software ownership not kept after access");

    chk_serial_hold: assert property (
        serial_q && !wrHit |=> $stable(cfgImage_q)
    ) else $error("image changed under software ownership");

    chk_strap_sync: assert property (
        settleCnt_q == 2'h3 |-> strapSync == $past(strapRaw, 2)
    ) else $error("strap bundle not delayed by two flops");

    chk_bus_answer: assert property (
        freshRequest |=> !waitreq_q ##1 waitreq_q
    ) else $error("bus answer not one cycle after request");

    chk_aux_code: assert property (
        mirrorCycle |=> auxModes[SRC_LSB +: 2] == $past(refSource)
    ) else $error("aux source does not follow strap code");

    chk_preemph_code: assert property (
        mirrorCycle |=> txSettings[PE_LSB +: 2] == $past(refPreemph)
    ) else $error("pre-emphasis does not follow strap code");

    chk_eq_replicated: assert property (
        mirrorCycle |=> rxEq2 == {REG_W{$past(refEqHigh)}}
    ) else $error("second equalizer image not the common strap level");

    chk_out_term_code: assert property (
        mirrorCycle |=> txSettings[OTO_BIT] == $past(refOutTerm)
    ) else $error("output termination does not follow strap code");

    chk_drive_code: assert property (
        mirrorCycle |=> txSettings[OCL_BIT] == $past(refCurrent20)
    ) else $error("output current does not follow strap code");

    chk_straps_keep: assert property (
        mirrorCycle |=> !serial_q
    ) else $error("software ownership taken without an access");

    chk_wait_idle: assert property (
        !(read || write) && waitreq_q |=> waitreq_q
    ) else $error("waitrequest dropped with no request");

    chk_write_lands: assert property (
        wrHit |=> cfgImage_q[$past(regIdx[2:0])] == $past(writedata[REG_W-1:0])
    ) else $error("accepted write did not reach its register");

    chk_status_read: assert property (
        read && waitreq_q && aligned && regIdx == IDX_STATUS && serial_q
        |=> readdata[SERIAL_BIT]
    ) else $error("status read does not show software ownership");

    chk_misaligned_zero: assert property (
        read && waitreq_q && !aligned |=> readdata == 32'h0
    ) else $error("misaligned read returned data");

    chk_read_upper_zero: assert property (
        readdata[31:REG_W] == '0
    ) else $error("unused read data bits not zero");

endmodule : parallel_pin_config_decoder
`default_nettype wire

// file: strap_board_model.sv
`default_nettype none
module strap_board_model
    import strap_cfg_pkg::*;
(
    input  wire logic [STRAP_W-1:0] tieLevels,
    output logic                    channel_enable_strap,
    output logic      [1:0]         source_select_strap,
    output logic                    equalizer_level_strap,
    output logic      [1:0]         preemphasis_level_strap,
    output logic                    output_termination_strap,
    output logic                    output_current_strap
);
    timeunit 1ns;
    timeprecision 1ps;

    // Each pin is a plain tie to supply or ground; levels only move when the bench re-straps
    assign channel_enable_strap     = tieLevels[SP_EN];
    assign source_select_strap      = tieLevels[SP_SRC+:2];
    assign equalizer_level_strap    = tieLevels[SP_EQ];
    assign preemphasis_level_strap  = tieLevels[SP_PE+:2];
    assign output_termination_strap = tieLevels[SP_OTO];
    assign output_current_strap     = tieLevels[SP_OCL];
endmodule : strap_board_model
`default_nettype wire

// file: parallel_pin_config_decoder_tb.sv
`default_nettype none
module parallel_pin_config_decoder_tb
    import strap_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic              core_clk, rst, read, write, waitrequest, serialMode;
    logic              enS, eqS, otoS, oclS;
    logic [1:0]        srcS, peS;
    logic [ADDR_W-1:0] address;
    logic [31:0]       writedata, readdata;
    logic [3:0]        byteenable;
    logic [7:0]        hsModes, auxModes, rxSettings, termPulse1, termPulse2;
    logic [7:0]        rxEq1, rxEq2, txSettings, ties, q;
    int                err_total, cmp_count, seed;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, board straps and device
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    strap_board_model u_strap_board_model (
        .tieLevels(ties), .channel_enable_strap(enS), .source_select_strap(srcS),
        .equalizer_level_strap(eqS), .preemphasis_level_strap(peS),
        .output_termination_strap(otoS), .output_current_strap(oclS));

    parallel_pin_config_decoder u_parallel_pin_config_decoder (
        .core_clk(core_clk), .rst(rst), .channel_enable_strap(enS),
        .source_select_strap(srcS), .equalizer_level_strap(eqS),
        .preemphasis_level_strap(peS), .output_termination_strap(otoS),
        .output_current_strap(oclS), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .hsModes(hsModes), .auxModes(auxModes),
        .rxSettings(rxSettings), .termPulse1(termPulse1), .termPulse2(termPulse2),
        .rxEq1(rxEq1), .rxEq2(rxEq2), .txSettings(txSettings), .serialMode(serialMode));

    ////////////////////////////////////////////////////////////////////////////////
    // Checking helpers
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Control image implied by a strap setting, register k of the map
    function automatic logic [7:0] expReg(input logic [7:0] t, input int k);
        case (k)
            0: return {1'b0, t[SP_EN], BUNDLE_QUAD, 2'h0, t[SP_SRC+:2]};
            1: return {1'b0, SWITCH_ON, BUNDLE_QUAD, 2'h0, t[SP_SRC+:2]};
            2: return {7'h00, RX_TERM_ON};
            5, 6: return {8{t[SP_EQ]}};
            7: return {4'h0, t[SP_PE+:2], t[SP_OTO], t[SP_OCL]};
            default: return PULSE_OFF;
        endcase
    endfunction : expReg

    task automatic checkAll(input logic [7:0] t);
        check(hsModes, expReg(t, 0));
        check(auxModes, expReg(t, 1));
        check(rxSettings, expReg(t, 2));
        check(termPulse1, expReg(t, 3));
        check(termPulse2, expReg(t, 4));
        check(rxEq1, expReg(t, 5));
        check(rxEq2, expReg(t, 6));
        check(txSettings, expReg(t, 7));
    endtask : checkAll

    // Straps are re-tied under reset, then given time to cross the synchroniser
    task automatic strapReset(input logic [7:0] t);
        @(posedge core_clk);
        rst  <= 1'b1;
        ties <= t;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        repeat (5) @(posedge core_clk);
        #1;
    endtask : strapReset

    // One Avalon access; request held until waitrequest is sampled low
    task automatic busXfer(input logic wr, input logic [5:0] a, input logic [7:0] d,
                           output logic [7:0] rd);
        @(posedge core_clk);
        address   <= a;
        writedata <= {24'h0, d};
        write     <= wr;
        read      <= ~wr;
        // Waits as long as it takes; only the watchdog ends a stuck access
        do begin
            @(posedge core_clk);
        end while (waitrequest !== 1'b0);
        rd = readdata[7:0];
        check(readdata[31:24] | readdata[23:16] | readdata[15:8], 8'h00);
        read  <= 1'b0;
        write <= 1'b0;
    endtask : busXfer

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog: the whole sequence needs well under 10 us
    initial begin
        #200000;
        err_total++;
        tally_and_finish();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [7:0] t;
        seed = 38071;
        err_total = 0;
        cmp_count = 0;
        rst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = '0;
        writedata = 32'h0;
        byteenable = 4'h1;
        ties = 8'h00;
        // Every source and pre-emphasis code, other straps random, both extremes
        for (int i = 0; i < 16; i++) begin
            t = 8'($random(seed));
            if (i == 0) t = 8'h00;
            if (i == 15) t = 8'hff;
            t[SP_SRC+:2] = 2'(i);
            t[SP_PE+:2]  = 2'(i >> 2);
            strapReset(t);
            checkAll(t);
            check({7'h0, serialMode}, 8'h00);
            check({7'h0, waitrequest}, 8'h01);
            $display("test strap %0d done", i);
        end
        // Two synchroniser stages plus the image register: visible at third edge
        @(posedge core_clk);
        ties <= ~t;
        repeat (2) @(posedge core_clk);
        #1;
        checkAll(t);
        @(posedge core_clk);
        #1;
        checkAll(~t);
        $display("test latency done");
        // First access hands control to software; straps then ignored
        t = 8'h5c;
        strapReset(t);
        busXfer(1'b0, 6'h20, 8'h00, q);
        check(q, 8'h00);
        ties <= ~t;
        #1;
        check({7'h0, serialMode}, 8'h01);
        repeat (6) @(posedge core_clk);
        #1;
        checkAll(t);
        busXfer(1'b0, 6'h14, 8'h00, q);
        check(q, expReg(t, 5));
        busXfer(1'b0, 6'h20, 8'h00, q);
        check(q, 8'h01);
        busXfer(1'b1, 6'h1c, 8'ha5, q);
        busXfer(1'b0, 6'h1c, 8'h00, q);
        check(q, 8'ha5);
        // Writes without the low byte lane, and to status, change nothing
        byteenable <= 4'h0;
        busXfer(1'b1, 6'h00, 8'h33, q);
        byteenable <= 4'h1;
        busXfer(1'b1, 6'h20, 8'h00, q);
        busXfer(1'b0, 6'h00, 8'h00, q);
        check(q, expReg(t, 0));
        busXfer(1'b0, 6'h20, 8'h00, q);
        check(q, 8'h01);
        busXfer(1'b0, 6'h22, 8'h00, q);
        check(q, 8'h00);
        busXfer(1'b0, 6'h24, 8'h00, q);
        check(q, 8'h00);
        $display("test handover done");
        tally_and_finish();
    end
endmodule : parallel_pin_config_decoder_tb
`default_nettype wire
